// *** rtl/scs_top.sv ***
// Purpose: serial port configuration and status register with its shift engine
// Assumes: core clock 10 MHz, serial clock a separate domain in slave role
// Notes: received bytes queue in a FIFO read through the rx stream port
//
// Behaviour
// R1: busy bit high while a transfer runs
// R2: bit 6 picks slave or master role
// R3: phase bit picks first or second edge
// R4: polarity bit sets serial clock idle level
// R5: selected flag from de-glitched select input
// R6: raw bit shows select pin level
// R7: slave shift empty set after finished byte
// R8: shift empty cleared on load or clock
// R9: master reports shift empty as one
// R10: receive empty follows unread slave data
// R11: master reports receive empty as one
// R12: slave samples incoming data mid-bit
// R13: master samples one clock before bit end
// R14: slave counts eight edges, stores byte
// R15: busy clears when byte transfer ends
// R16: status bits ignore software writes
`timescale 1ns/100ps
module scs_top
	import scs_pkg::*;
#(
	parameter logic [7:0] CFG_ADDR = SCS_ADDR_PORT0
) (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic sfr_rd_in,
	input wire logic [7:0] sfr_wdata_in,
	output logic [7:0] sfr_rdata_out,
	input wire logic [7:0] tx_data_in,
	input wire logic tx_valid_in,
	output logic tx_ready_out,
	output logic [7:0] rx_data_out,
	output logic rx_valid_out,
	input wire logic rx_ready_in,
	input wire logic sck_clk_in,
	output logic sck_out,
	output logic sck_oe_out,
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe_out,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe_out,
	input wire logic nss_in
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	scs_cfg_t cfg_reg, cfg_next; // Writable configuration
	logic [3:0] sy1_reg, sy2_reg; // Sync chains: nss, miso, done, edge
	logic [1:0] sy3_reg; // Third stage of event toggles
	logic nss_s, miso_s; // Synchronised pin levels
	logic done_ev, edge_ev; // One-cycle link events
	logic filt_reg, filt_next; // De-glitched select level
	logic [1:0] degl_reg, degl_next; // Stability counter
	logic clr_reg; // Link-side clear, held through reset
	logic [7:0] txb_reg, txb_next; // Transmit buffer
	logic txb_full_reg, txb_full_next; // Transmit buffer holds a byte
	logic txr_reg; // Transmit ready
	logic [7:0] shf_reg, shf_next; // Shift register image
	logic shf_full_reg, shf_full_next; // Shift register loaded
	logic shift_empty_flag_reg, shift_empty_flag_next; // Shift empty flag
	logic busy_reg, busy_next; // Transfer active flag
	logic rxe_reg; // Receive empty flag
	logic [7:0] rd_reg, rd_next; // Read data
	scs_mstate_t mst_reg, mst_next; // Master engine state
	logic [1:0] cyc_reg, cyc_next; // Cycle within bit
	logic [2:0] bit_reg, bit_next; // Bit index
	logic samp_reg, samp_next; // Sampled slave bit
	logic sck_reg, sck_next; // Driven serial clock
	logic mosi_reg; // Driven master data
	logic oe_m_reg, oe_s_reg; // Pin enables
	logic push; // Byte into FIFO
	logic [7:0] push_data; // Byte offered to FIFO
	logic fifo_ready; // FIFO has room
	logic sel; // Addressed by the register bus
	logic slave_sel; // Selected as slave
	logic tx_take; // Transmit byte accepted
	logic load; // Buffer into shift register
	scs_link_t link; // Link-domain outputs
	logic link_miso; // Link-domain outgoing bit
	// ----------------------------------------------------------------
	// Link shifter and receive FIFO
	// ----------------------------------------------------------------
	scs_link u_link (
		.sck_clk_in(sck_clk_in),
		.nss_in(nss_in),
		.clr_in(clr_reg),
		.mosi_in(mosi_in),
		.cfg_in(cfg_reg),
		.tx_byte_in(shf_reg),
		.link_out(link),
		.miso_out(link_miso)
	);
	scs_fifo #(.WIDTH(SCS_BYTE_BITS), .DEPTH(SCS_FIFO_DEPTH)) u_fifo (
		.core_clk_in(core_clk_in),
		.nrst_in(nrst_in),
		.in_data_in(push_data),
		.in_valid_in(push),
		.in_ready_out(fifo_ready),
		.out_data_out(rx_data_out),
		.out_valid_out(rx_valid_out),
		.out_ready_in(rx_ready_in)
	);
	// ----------------------------------------------------------------
	// Synchronisers and event detection
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in)
	begin
		if (!nrst_in)
		begin
			sy1_reg <= {1'b1, 3'h0}; // Select idles high, no false select
			sy2_reg <= {1'b1, 3'h0};
			sy3_reg <= 2'h0;
			clr_reg <= 1'b1;
		end
		else
		begin
			sy1_reg <= {nss_in, miso_in, link.done_tgl, link.edge_tgl};
			sy2_reg <= sy1_reg;
			sy3_reg <= sy2_reg[1:0];
			clr_reg <= 1'b0;
		end
	end
	assign nss_s = sy2_reg[3];
	assign miso_s = sy2_reg[2];
	assign done_ev = sy2_reg[1] ^ sy3_reg[1];
	assign edge_ev = sy2_reg[0] ^ sy3_reg[0];
	// ----------------------------------------------------------------
	// Select de-glitch: level must hold before it is accepted
	// ----------------------------------------------------------------
	always_comb
	begin
		filt_next = filt_reg;
		degl_next = 2'h0;
		// Count while the input differs from the accepted level
		if (nss_s != filt_reg)
		begin
			degl_next = degl_reg + 2'h1;
			if (degl_reg == SCS_DEGL_END)
			begin
				filt_next = nss_s; // R5
				degl_next = 2'h0;
			end
		end
	end
	always_ff @(posedge core_clk_in)
	begin
		if (!nrst_in)
		begin
			filt_reg <= 1'b1;
			degl_reg <= 2'h0;
		end
		else
		begin
			filt_reg <= filt_next;
			degl_reg <= degl_next;
		end
	end
	assign slave_sel = !filt_reg && !cfg_reg.master;
	// ----------------------------------------------------------------
	// Register access: only role, phase and polarity take writes
	// ----------------------------------------------------------------
	assign sel = (sfr_addr_in == CFG_ADDR);
	always_comb
	begin
		cfg_next = cfg_reg;
		rd_next = rd_reg;
		// Write touches the three writable bits
		if (sfr_wr_in && sel)
		begin
			cfg_next.master = sfr_wdata_in[SCS_MST_BIT]; // R2
			cfg_next.cpha = sfr_wdata_in[SCS_CPHA_BIT]; // R3
			cfg_next.cpol = sfr_wdata_in[SCS_CPOL_BIT]; // R4 R16
		end
		// Read returns status with live select pin level
		if (sfr_rd_in && sel)
		begin
			rd_next = SCS_RD_UNMAPPED;
			rd_next[SCS_BUSY_BIT] = busy_reg; // R1
			rd_next[SCS_MST_BIT] = cfg_reg.master;
			rd_next[SCS_CPHA_BIT] = cfg_reg.cpha;
			rd_next[SCS_CPOL_BIT] = cfg_reg.cpol;
			rd_next[SCS_SEL_BIT] = !filt_reg; // R5
			rd_next[SCS_RAW_BIT] = nss_s; // R6
			rd_next[SCS_SHIFT_EMPTY_FLAG_BIT] = shift_empty_flag_reg || cfg_reg.master; // R9
			rd_next[SCS_RXE_BIT] = rxe_reg;
		end
		else if (sfr_rd_in)
		begin
			rd_next = SCS_RD_UNMAPPED;
		end
	end
	// ----------------------------------------------------------------
	// Transmit buffer, shift register load and flags
	// ----------------------------------------------------------------
	assign tx_take = tx_valid_in && txr_reg;
	always_comb
	begin
		txb_next = txb_reg;
		txb_full_next = txb_full_reg;
		shf_next = shf_reg;
		shf_full_next = shf_full_reg;
		shift_empty_flag_next = shift_empty_flag_reg;
		busy_next = busy_reg;
		load = 1'b0;
		// Accept a new byte into the buffer
		if (tx_take)
		begin
			txb_next = tx_data_in;
			txb_full_next = 1'b1;
		end
		// Slave byte finished: shift register frees up
		if (done_ev && !cfg_reg.master)
		begin
			shf_full_next = 1'b0;
		end
		// Master engine shifts in place and frees at the end
		if (mst_reg == SCS_M_SHIFT && cyc_reg == SCS_BIT_END)
		begin
			shf_next = {shf_reg[6:0], samp_reg};
		end
		if (mst_reg == SCS_M_DONE)
		begin
			shf_full_next = 1'b0;
		end
		// Empty shift register takes the buffered byte while the master engine is idle
		if (!shf_full_next && txb_full_reg && mst_reg == SCS_M_IDLE)
		begin
			load = 1'b1;
			shf_next = txb_reg;
			shf_full_next = 1'b1;
			txb_full_next = tx_take;
		end
		// Shift empty: clear on load or clock, set after a byte
		if (cfg_reg.master)
		begin
			shift_empty_flag_next = 1'b1; // R9
		end
		else if (done_ev && !load)
		begin
			shift_empty_flag_next = 1'b1; // R7
		end
		else if (load || edge_ev)
		begin
			shift_empty_flag_next = 1'b0; // R8
		end
		// Busy: slave from first edge to byte end
		if (cfg_reg.master)
		begin
			busy_next = (mst_next != SCS_M_IDLE) || shf_full_next; // R1
		end
		else if (done_ev || !slave_sel)
		begin
			busy_next = 1'b0; // R15
		end
		else if (edge_ev)
		begin
			busy_next = 1'b1; // R1
		end
	end
	// ----------------------------------------------------------------
	// Master engine: clock generation and sampling
	// ----------------------------------------------------------------
	always_comb
	begin
		mst_next = mst_reg;
		cyc_next = cyc_reg;
		bit_next = bit_reg;
		samp_next = samp_reg;
		case (mst_reg)
			SCS_M_IDLE:
			begin
				// Start once a byte sits in the shift register
				if (cfg_reg.master && shf_full_reg)
				begin
					mst_next = SCS_M_SHIFT;
					cyc_next = 2'h0;
					bit_next = 3'h0;
				end
			end
			SCS_M_SHIFT:
			begin
				cyc_next = cyc_reg + 2'h1;
				// Late sample gives the slave settling time
				if (cyc_reg == SCS_SAMP_CYC)
				begin
					samp_next = miso_s; // R13
				end
				// End of bit period
				if (cyc_reg == SCS_BIT_END)
				begin
					cyc_next = 2'h0;
					bit_next = bit_reg + 3'h1;
					if (bit_reg == SCS_LAST_BIT)
					begin
						mst_next = SCS_M_DONE;
					end
				end
			end
			SCS_M_DONE:
			begin
				mst_next = SCS_M_IDLE;
			end
			default:
			begin
				mst_next = SCS_M_IDLE;
			end
		endcase
		// Active half: second for phase 0, first for phase 1
		sck_next = cfg_reg.cpol; // R4
		if (mst_next == SCS_M_SHIFT)
		begin
			sck_next = cfg_reg.cpol ^ (cfg_reg.cpha ? (cyc_next < SCS_HALF)
				: (cyc_next >= SCS_HALF)); // R3
		end
	end
	// ----------------------------------------------------------------
	// Received bytes into the FIFO, dropped when full
	// ----------------------------------------------------------------
	assign push = ((done_ev && !cfg_reg.master) || mst_reg == SCS_M_DONE) && fifo_ready;
	assign push_data = cfg_reg.master ? shf_reg : link.rx_byte; // R14
	// ----------------------------------------------------------------
	// Core registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in)
	begin
		if (!nrst_in)
		begin
			cfg_reg <= '0;
			rd_reg <= SCS_RD_UNMAPPED;
			txb_reg <= 8'h00;
			txb_full_reg <= 1'b0;
			txr_reg <= 1'b0;
			shf_reg <= 8'h00;
			shf_full_reg <= 1'b0;
			shift_empty_flag_reg <= 1'b1;
			busy_reg <= 1'b0;
			rxe_reg <= 1'b1;
			mst_reg <= SCS_M_IDLE;
			cyc_reg <= 2'h0;
			bit_reg <= 3'h0;
			samp_reg <= 1'b0;
			sck_reg <= 1'b0;
			mosi_reg <= 1'b0;
			oe_m_reg <= 1'b0;
			oe_s_reg <= 1'b0;
		end
		else
		begin
			cfg_reg <= cfg_next;
			rd_reg <= rd_next;
			txb_reg <= txb_next;
			txb_full_reg <= txb_full_next;
			txr_reg <= !txb_full_next;
			shf_reg <= shf_next;
			shf_full_reg <= shf_full_next;
			shift_empty_flag_reg <= shift_empty_flag_next;
			busy_reg <= busy_next;
			rxe_reg <= cfg_next.master || !rx_valid_out; // R10 R11
			mst_reg <= mst_next;
			cyc_reg <= cyc_next;
			bit_reg <= bit_next;
			samp_reg <= samp_next;
			sck_reg <= sck_next;
			mosi_reg <= shf_next[7];
			oe_m_reg <= cfg_next.master; // R2
			oe_s_reg <= slave_sel;
		end
	end
	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign sfr_rdata_out = rd_reg;
	assign tx_ready_out = txr_reg;
	assign sck_out = sck_reg;
	assign sck_oe_out = oe_m_reg;
	assign mosi_out = mosi_reg;
	assign mosi_oe_out = oe_m_reg;
	assign miso_out = link_miso;
	assign miso_oe_out = oe_s_reg;
endmodule

// *** rtl/scs_pkg.sv ***
// Purpose: shared constants and types of the serial port configuration block
// Assumes: one port per instance, 8-bit special-function register space
// Notes: both port addresses are kept, the top picks one by parameter
package scs_pkg;
	// ----------------------------------------------------------------
	// Register addresses and field positions
	// ----------------------------------------------------------------
	localparam logic [7:0] SCS_ADDR_PORT0 = 8'ha1; // Port zero config
	localparam logic [7:0] SCS_ADDR_PORT1 = 8'h84; // Port one config
	localparam int SCS_BUSY_BIT = 7; // Transfer active flag
	localparam int SCS_MST_BIT = 6; // Master role select
	localparam int SCS_CPHA_BIT = 5; // Clock phase
	localparam int SCS_CPOL_BIT = 4; // Clock idle level
	localparam int SCS_SEL_BIT = 3; // Selected filtered flag
	localparam int SCS_RAW_BIT = 2; // Select pin raw
	localparam int SCS_SHIFT_EMPTY_FLAG_BIT = 1; // Shift empty flag
	localparam int SCS_RXE_BIT = 0; // Receive empty flag
	localparam logic [7:0] SCS_RD_UNMAPPED = 8'h00; // Unmapped read value
	// ----------------------------------------------------------------
	// Sizes and timing
	// ----------------------------------------------------------------
	localparam int SCS_BYTE_BITS = 8; // Bits per byte
	localparam logic [2:0] SCS_LAST_BIT = 3'h7; // Index of last bit
	localparam int SCS_FIFO_DEPTH = 16; // Receive FIFO words
	localparam int SCS_HALF_CYC = 2; // Master clock half period, cycles
	localparam int SCS_BIT_CYC = 2 * SCS_HALF_CYC; // Master bit period, cycles
	localparam int SCS_SAMPLE_LEAD = 1; // Sample this many clocks before bit end
	localparam logic [1:0] SCS_HALF = 2'(SCS_HALF_CYC); // Half period, sized
	localparam logic [1:0] SCS_BIT_END = 2'(SCS_BIT_CYC - 1); // Last cycle of bit
	localparam logic [1:0] SCS_SAMP_CYC = 2'(SCS_BIT_CYC - 1 - SCS_SAMPLE_LEAD);
	localparam logic [1:0] SCS_DEGL_END = 2'h1; // Stable samples - 1 to accept select
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic master; // Master role select
		logic cpha; // Clock phase
		logic cpol; // Clock idle level
	} scs_cfg_t;
	typedef struct packed
	{
		logic done_tgl; // Toggles at each finished byte
		logic edge_tgl; // Toggles at each sampling edge
		logic [7:0] rx_byte; // Last byte received
	} scs_link_t;
	typedef enum logic [1:0]
	{
		SCS_M_IDLE = 2'b00,
		SCS_M_SHIFT = 2'b01,
		SCS_M_DONE = 2'b10
	} scs_mstate_t;
endpackage

// *** rtl/scs_fifo.sv ***
// Purpose: small synchronous FIFO with registered output stage
// Assumes: one clock, synchronous active-low reset
// Notes: holds DEPTH words in memory plus one in the output stage
`timescale 1ns/100ps
module scs_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic [WIDTH-1:0] in_data_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	output logic [WIDTH-1:0] out_data_out,
	output logic out_valid_out,
	input wire logic out_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH]; // Storage
	logic [AW-1:0] wptr_reg, wptr_next; // Write pointer
	logic [AW-1:0] rptr_reg, rptr_next; // Read pointer
	logic [AW:0] cnt_reg, cnt_next; // Words in memory
	logic [WIDTH-1:0] out_reg, out_next; // Output stage data
	logic oval_reg, oval_next; // Output stage valid
	logic push, pop; // Memory write and read
	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		push = in_valid_in && (cnt_reg != (AW+1)'(DEPTH));
		pop = (cnt_reg != '0) && (!oval_reg || out_ready_in);
		wptr_next = push ? wptr_reg + 1'b1 : wptr_reg;
		rptr_next = pop ? rptr_reg + 1'b1 : rptr_reg;
		cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		out_next = pop ? mem_reg[rptr_reg] : out_reg;
		// Output empties when taken and nothing follows
		oval_next = pop ? 1'b1 : (oval_reg && !out_ready_in);
	end
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in)
	begin
		if (push)
		begin
			mem_reg[wptr_reg] <= in_data_in;
		end
		if (!nrst_in)
		begin
			wptr_reg <= '0;
			rptr_reg <= '0;
			cnt_reg <= '0;
			out_reg <= '0;
			oval_reg <= 1'b0;
		end
		else
		begin
			wptr_reg <= wptr_next;
			rptr_reg <= rptr_next;
			cnt_reg <= cnt_next;
			out_reg <= out_next;
			oval_reg <= oval_next;
		end
	end
	assign in_ready_out = (cnt_reg != (AW+1)'(DEPTH)); // Honest full
	assign out_data_out = out_reg;
	assign out_valid_out = oval_reg;
endmodule

// *** rtl/scs_link.sv ***
// Purpose: slave-side shifter running on the serial clock
// Assumes: phase and polarity stay fixed while the port is selected
// Notes: select high or clear resets the bit counter asynchronously
`timescale 1ns/100ps
module scs_link
	import scs_pkg::*;
(
	input wire logic sck_clk_in,
	input wire logic nss_in,
	input wire logic clr_in,
	input wire logic mosi_in,
	input wire scs_cfg_t cfg_in,
	input wire logic [7:0] tx_byte_in,
	output scs_link_t link_out,
	output logic miso_out
);
	logic eff_clk; // Sampling clock, rising at the data centre
	logic cnt_rst; // Counter reset, select high or clear
	logic [2:0] cnt_reg, cnt_next; // Bits sampled so far
	logic [7:0] shift_reg, shift_next; // Incoming bits
	logic [7:0] rx_reg, rx_next; // Finished byte
	logic done_reg, done_next; // Byte finished toggle
	logic edge_reg, edge_next; // Clock edge toggle
	logic [2:0] out_cnt_reg, out_cnt_next; // Bits launched so far
	assign eff_clk = sck_clk_in ^ cfg_in.cpol ^ cfg_in.cpha;
	assign cnt_rst = nss_in | clr_in;
	// ----------------------------------------------------------------
	// Next state at each sampling edge
	// ----------------------------------------------------------------
	always_comb
	begin
		shift_next = {shift_reg[6:0], mosi_in}; // R12
		cnt_next = cnt_reg + 3'h1;
		edge_next = ~edge_reg;
		out_cnt_next = out_cnt_reg + 3'h1;
		rx_next = rx_reg;
		done_next = done_reg;
		// Eighth bit closes the byte
		if (cnt_reg == SCS_LAST_BIT)
		begin
			rx_next = shift_next; // R14
			done_next = ~done_reg; // R14
		end
	end
	// ----------------------------------------------------------------
	// Bit counter and shifter, reset by deselect
	// ----------------------------------------------------------------
	always_ff @(posedge eff_clk or posedge cnt_rst)
	begin
		if (cnt_rst)
		begin
			cnt_reg <= 3'h0;
			shift_reg <= 8'h00;
		end
		else
		begin
			cnt_reg <= cnt_next; // R14
			shift_reg <= shift_next;
		end
	end
	// ----------------------------------------------------------------
	// Event toggles and received byte, reset by core only
	// ----------------------------------------------------------------
	always_ff @(posedge eff_clk or posedge clr_in)
	begin
		if (clr_in)
		begin
			rx_reg <= 8'h00;
			done_reg <= 1'b0;
			edge_reg <= 1'b0;
		end
		else
		begin
			rx_reg <= rx_next;
			done_reg <= done_next;
			edge_reg <= edge_next;
		end
	end
	// ----------------------------------------------------------------
	// Launch counter steps half a bit away from sampling
	// ----------------------------------------------------------------
	always_ff @(negedge eff_clk or posedge cnt_rst)
	begin
		if (cnt_rst)
		begin
			out_cnt_reg <= 3'h0;
		end
		else
		begin
			out_cnt_reg <= out_cnt_next;
		end
	end
	assign link_out = '{done_tgl: done_reg, edge_tgl: edge_reg, rx_byte: rx_reg};
	// Phase 0 needs the top bit before any edge, so the bit is picked, not stored
	assign miso_out = tx_byte_in[SCS_LAST_BIT - (out_cnt_reg - {2'h0, cfg_in.cpha})]; // R3
endmodule

// *** verif/scs_props.sv ***
// Purpose: port-level checks of the serial port config block
// Assumes: single core clock domain seen at the top ports
// Notes: bound into every scs_top instance
`timescale 1ns/100ps
module scs_props
	import scs_pkg::*;
#(
	parameter logic [7:0] CFG_ADDR = SCS_ADDR_PORT0
) (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic sfr_rd_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic [7:0] sfr_rdata_out,
	input wire logic tx_valid_in,
	input wire logic tx_ready_out,
	input wire logic [7:0] rx_data_out,
	input wire logic rx_valid_out,
	input wire logic rx_ready_in,
	input wire logic sck_out,
	input wire logic sck_oe_out,
	input wire logic miso_oe_out,
	input wire logic nss_in
);
	logic hit; // Config address decoded
	assign hit = sfr_addr_in == CFG_ADDR;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);
	unmapped_read_a:
		assert property (sfr_rd_in && !hit |=> sfr_rdata_out == 8'h00) else $error("bad unmapped");
	master_empties_a:
		assert property (sfr_rd_in && hit && !sfr_wr_in && sck_oe_out
			|=> sfr_rdata_out[1:0] == 2'h3) else $error("master empties");
	role_select_a:
		assert property (sfr_wr_in && hit && sfr_wdata_in[6] |-> ##[1:2] sck_oe_out)
			else $error("role not taken");
	idle_level_a:
		assert property (sfr_rd_in && hit && !sfr_wr_in && sck_oe_out && tx_ready_out
			&& !tx_valid_in ##1 !sfr_rdata_out[7] |-> sck_out == sfr_rdata_out[4])
			else $error("idle level");
	raw_pin_a:
		assert property (sfr_rd_in && hit |=> sfr_rdata_out[2] == $past(nss_in, 2))
			else $error("raw pin");
	deselect_quiet_a:
		assert property (nss_in [*8] |-> !miso_oe_out) else $error("driven while idle");
	slave_rxempty_a:
		assert property (sfr_rd_in && hit && !sfr_wr_in && !sck_oe_out && !rx_ready_in
			|=> sfr_rdata_out[0] == !$past(rx_valid_out)) else $error("rx empty");
	rx_hold_a:
		assert property (rx_valid_out && !rx_ready_in |=> rx_valid_out && $stable(rx_data_out))
			else $error("rx head moved");
	tx_take_a:
		assert property (tx_valid_in && tx_ready_out |=> !tx_ready_out) else $error("tx take");
	rdata_hold_a:
		assert property (!sfr_rd_in |=> $stable(sfr_rdata_out)) else $error("rdata moved");
endmodule
bind scs_top scs_props #(.CFG_ADDR(CFG_ADDR)) scs_props_inst (.*);

// *** verif/scs_peer.sv ***
// Purpose: far-side serial device, slave responder and master driver
// Assumes: responder works in phase 0 polarity 0
// Notes: link clock stands still between frames
`timescale 1ns/100ps
module scs_peer (
	input wire logic sck_in,
	input wire logic mosi_in,
	input wire logic miso_in,
	output logic miso_out,
	output logic sck_out,
	output logic mosi_out,
	output logic nss_out
);
	logic [7:0] reply = 8'ha5; // Responder byte, rotates
	logic [7:0] got = 8'h00; // Byte seen from master
	initial
	begin
		sck_out = 1'b0;
		mosi_out = 1'b0;
		nss_out = 1'b1;
	end
	assign miso_out = reply[7];
	always @(posedge sck_in) got <= {got[6:0], mosi_in};
	always @(negedge sck_in) reply <= {reply[6:0], reply[7]};
	// Master frame, MSB first
	task automatic xfer(input logic [7:0] b, input logic cpol, input logic cpha,
		output logic [7:0] r);
		sck_out = cpol;
		#100 nss_out = 1'b0;
		#800;
		for (int i = 7; i >= 0; i--)
		begin
			if (!cpha) mosi_out = b[i];
			#16 sck_out = !cpol;
			if (cpha) mosi_out = b[i];
			else r = {r[6:0], miso_in};
			#16 sck_out = cpol;
			if (cpha) r = {r[6:0], miso_in};
		end
		#400 nss_out = 1'b1;
		mosi_out = !mosi_out; // Released line flips
	endtask
endmodule

// *** verif/scs_bench.sv ***
// Purpose: self-checking bench of the serial port config block
// Assumes: 10 MHz core clock, 32 ns link clock from the peer
// Notes: table rows for slave modes, then hand tests
`timescale 1ns/100ps
module scs_bench;
	import scs_pkg::*;
	logic clk = 0, nrst = 0, wr = 0, rd = 0, txv = 0, rxr = 0;
	logic [7:0] addr = SCS_ADDR_PORT0, wd = 8'h00, txd = 8'h00, v, r;
	int n_fail = 0, compares = 0, cnt;
	wire sck, sck_oe, mo, mo_oe, mi, mi_oe, psck, pmo, pmi, slave_select_input, txr, rxv;
	wire sckw = sck_oe ? sck : psck; // Resolved pins
	wire mosiw = mo_oe ? mo : pmo;
	wire misow = mi_oe ? mi : pmi;
	wire [7:0] rdata, rxd;
	logic [7:0] rows [4][3] = '{'{8'h20, 8'h96, 8'h5a}, '{8'h00, 8'h3c, 8'hc3},
		'{8'h10, 8'h81, 8'h7e}, '{8'h30, 8'hf0, 8'h0f}}; // Config, sent, reply
	always #50 clk = ~clk;
	scs_top scs_top_inst (.core_clk_in(clk), .nrst_in(nrst), .sfr_addr_in(addr),
		.sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_wdata_in(wd), .sfr_rdata_out(rdata),
		.tx_data_in(txd), .tx_valid_in(txv), .tx_ready_out(txr), .rx_data_out(rxd),
		.rx_valid_out(rxv), .rx_ready_in(rxr), .sck_clk_in(sckw), .sck_out(sck),
		.sck_oe_out(sck_oe), .mosi_in(mosiw), .mosi_out(mo), .mosi_oe_out(mo_oe),
		.miso_in(misow), .miso_out(mi), .miso_oe_out(mi_oe), .nss_in(slave_select_input));
	scs_peer scs_peer_inst (.sck_in(sckw), .mosi_in(mosiw), .miso_in(misow),
		.miso_out(pmi), .sck_out(psck), .mosi_out(pmo), .nss_out(slave_select_input));
	task tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task chk(string what, logic [7:0] e, logic [7:0] s);
		compares++;
		if (s !== e)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, e, s);
		end
	endtask
	task wreg(logic [7:0] d);
		addr = SCS_ADDR_PORT0;
		wd = d;
		wr = 1;
		tick(1);
		wr = 0;
	endtask
	task rreg(logic [7:0] a);
		addr = a;
		rd = 1;
		tick(1);
		rd = 0;
		tick(1);
		v = rdata;
	endtask
	task push(logic [7:0] d);
		txd = d;
		txv = 1;
		for (int k = 0; k < 100 && txr !== 1'b1; k++) tick(1);
		tick(1);
		txv = 0;
		tick(1);
	endtask
	task report_and_stop;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		#3000000;
		n_fail++;
		report_and_stop;
	end
	initial
	begin
		tick(16);
		nrst = 1;
		tick(2);
		rreg(SCS_ADDR_PORT0);
		chk("reset value", 8'h07, v);
		wreg(8'hff);
		tick(1);
		rreg(SCS_ADDR_PORT0);
		chk("status write", 8'h77, v);
		rreg(SCS_ADDR_PORT1);
		chk("unmapped", 8'h00, v);
		wreg(8'h00);
		$display("test registers done");
		foreach (rows[i])
		begin
			wreg(rows[i][0]);
			push(rows[i][2]);
			scs_peer_inst.xfer(rows[i][1], rows[i][0][4], rows[i][0][5], r);
			tick(10);
			chk("slave rx", rows[i][1], rxd);
			chk("slave tx", rows[i][2], r);
			rreg(SCS_ADDR_PORT0);
			chk("after byte", rows[i][0] | 8'h06, v);
			rxr = 1;
			tick(1);
			rxr = 0;
			tick(3);
			rreg(SCS_ADDR_PORT0);
			chk("after pop", rows[i][0] | 8'h07, v);
		end
		$display("test slave modes done");
		scs_peer_inst.nss_out = 1'b0;
		tick(8);
		rreg(SCS_ADDR_PORT0);
		chk("selected", 8'h3b, v);
		scs_peer_inst.nss_out = 1'b1;
		tick(8);
		$display("test select done");
		wreg(8'h40);
		tick(1);
		scs_peer_inst.reply = 8'ha5; // Responder restarts after role switch edge
		push(8'h3c);
		tick(3);
		rreg(SCS_ADDR_PORT0);
		chk("busy", 8'h80, v & 8'h80);
		repeat (17) push(8'h3c);
		tick(100);
		chk("master out", 8'h3c, scs_peer_inst.got);
		rreg(SCS_ADDR_PORT0);
		chk("master idle", 8'h47, v);
		cnt = 0;
		rxr = 1;
		repeat (30)
		begin
			if (rxv === 1'b1)
			begin
				cnt++;
				chk("master rx", 8'ha5, rxd);
			end
			tick(1);
		end
		rxr = 0;
		chk("fifo count", 8'h11, 8'(cnt));
		$display("test master done");
		report_and_stop;
	end
endmodule
